//--- rpc_classifier.sv
`timescale 1ns/1ps
module rpc_classifier
   import rpc_pkg::*;
(
   input rpc_pkt_s pkt,
   input rpc_match_s cfg,
   output logic qualify
);

   // ****************************************************
   // Transport and message matching
   // ****************************************************
   logic l2Hit;
   logic l4Hit;
   logic isV1;
   logic isV2;
   logic v1Msg;
   logic v2Msg;

   // Both sides compared as carried, first wire byte high
   assign l2Hit = pkt.isL2 && (pkt.etherType == cfg.etherType);
   assign l4Hit = pkt.isUdp && (pkt.udpPort == cfg.udpPort);
   assign isV1 = pkt.ptpVersion == RPC_PTP_V1;
   assign isV2 = pkt.ptpVersion == RPC_PTP_V2;
   // Version 1 selects on control, version 2 on message id
   assign v1Msg = pkt.v1Control == cfg.v1Control;
   assign v2Msg = ({4'h0, pkt.messageId} == cfg.v2MessageId)
      || (pkt.messageId == RPC_MSG_ID_A)
      || (pkt.messageId == RPC_MSG_ID_B);

   // Mode decode; reserved codes never qualify
   always_comb begin
      case (cfg.mode)
         RPC_MODE_L2_V2: qualify = l2Hit && isV2 && v2Msg;
         RPC_MODE_L4_V1: qualify = l4Hit && isV1 && v1Msg;
         RPC_MODE_V2_ANY: begin
            qualify = (l2Hit || l4Hit) && isV2 && v2Msg;
         end
         RPC_MODE_ALL: qualify = 1'b1;
         RPC_MODE_EVENT_V2: begin
            qualify = (l2Hit || l4Hit) && isV2
               && !pkt.messageId[RPC_MSG_EVENT_BIT];
         end
         default: qualify = 1'b0;
      endcase
   end

endmodule // rpc_classifier

//--- rpc_pkg.sv
// ****************************************************
// Receive stamp capture: shared constants and types
// ****************************************************
package rpc_pkg;

   // ****************************************************
   // Register map (byte addresses)
   // ****************************************************
   localparam int RPC_ADDR_W = 16;
   localparam logic [15:0] RPC_OFF_CTRL = 16'hb620;
   localparam logic [15:0] RPC_OFF_STAMP_LOW = 16'hb624;
   localparam logic [15:0] RPC_OFF_STAMP_HIGH = 16'hb628;
   localparam logic [15:0] RPC_OFF_SRC_LOW = 16'hb62c;
   localparam logic [15:0] RPC_OFF_SRC_HIGH = 16'hb630;
   localparam logic [15:0] RPC_OFF_MATCH = 16'hb634;
   localparam logic [15:0] RPC_OFF_UDP = 16'hb638;
   localparam logic [15:0] RPC_OFF_IRQ_STAT = 16'hb640;
   localparam logic [15:0] RPC_OFF_IRQ_MASK = 16'hb644;

   // ****************************************************
   // Field positions and reset values
   // ****************************************************
   localparam int RPC_CTRL_VALID_BIT = 0;
   localparam int RPC_CTRL_TYPE_LSB = 1;
   localparam int RPC_CTRL_TYPE_MSB = 3;
   localparam int RPC_CTRL_EN_BIT = 4;
   localparam int RPC_MATCH_V1_LSB = 16;
   localparam int RPC_MATCH_V2_LSB = 24;
   localparam int RPC_SRC_HIGH_SEQ_LSB = 16;
   localparam logic [2:0] RPC_CTRL_TYPE_RST = 3'h0;
   localparam logic RPC_CTRL_EN_RST = 1'b0;
   localparam logic [31:0] RPC_MATCH_RST = 32'h000088f7;
   localparam logic [15:0] RPC_UDP_RST = 16'h0319;
   localparam int RPC_IRQ_W = 2;
   localparam int RPC_IRQ_CAPT_BIT = 0;
   localparam int RPC_IRQ_LOST_BIT = 1;
   localparam logic [1:0] RPC_IRQ_MASK_RST = 2'h0;

   // ****************************************************
   // Packet-type modes and PTP header codes
   // ****************************************************
   localparam logic [2:0] RPC_MODE_L2_V2 = 3'h0;
   localparam logic [2:0] RPC_MODE_L4_V1 = 3'h1;
   localparam logic [2:0] RPC_MODE_V2_ANY = 3'h2;
   localparam logic [2:0] RPC_MODE_ALL = 3'h4;
   localparam logic [2:0] RPC_MODE_EVENT_V2 = 3'h5;
   localparam logic [3:0] RPC_PTP_V1 = 4'h1;
   localparam logic [3:0] RPC_PTP_V2 = 4'h2;
   localparam logic [3:0] RPC_MSG_ID_A = 4'h2;
   localparam logic [3:0] RPC_MSG_ID_B = 4'h3;
   localparam int RPC_MSG_EVENT_BIT = 3;

   // Packet header summary from the receive path
   typedef struct packed {
      logic stampPoint;
      logic isL2;
      logic isUdp;
      logic [15:0] etherType;
      logic [15:0] udpPort;
      logic [3:0] ptpVersion;
      logic [3:0] messageId;
      logic [7:0] v1Control;
      logic [47:0] sourceId;
      logic [15:0] sequenceNum;
   } rpc_pkt_s;

   // Classifier configuration
   typedef struct packed {
      logic [2:0] mode;
      logic [15:0] etherType;
      logic [15:0] udpPort;
      logic [7:0] v1Control;
      logic [7:0] v2MessageId;
   } rpc_match_s;

endpackage

//--- rpc_rx_path_model.sv
`timescale 1ns/1ps
// ****************************************
// Receive path stand-in: packets and time
// ****************************************
module rpc_rx_path_model
   import rpc_pkg::*;
(
   input logic sys_clk,
   input logic rst_b,
   output rpc_pkt_s rxPkt,
   output logic [63:0] sysTime
);
   logic [63:0] stampAt;

   // Running time, started near a word carry so both halves move
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sysTime <= 64'h0000_0001_ffff_fff0;
      end else begin
         sysTime <= sysTime + 64'h1;
      end
   end

   // Idle fields never show a real header
   initial begin
      rxPkt = '1;
      rxPkt.stampPoint = 1'b0;
   end

   // One-cycle stamp point; notes the time the block samples
   task automatic send(input rpc_pkt_s p);
      rpc_pkt_s q;
      q = p;
      q.stampPoint = 1'b1;
      rxPkt <= q;
      @(posedge sys_clk);
      stampAt = sysTime;
      // Inverted leftovers so stale fields cannot pass as valid
      q = ~q;
      rxPkt <= q;
   endtask
endmodule // rpc_rx_path_model

//--- rpc_rx_stamp_capture.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - Valid flag set when stamp latched
// - Reading high stamp word clears valid
// - Mode 000: layer-2 version-2 packets only
// - Mode 001: UDP version-1 packets only
// - Mode 010: version-2 over layer 2 or 4
// - Message match value picks Sync or Delay_req; ids 2 and 3 always match
// - Mode 100: stamp all, no lock, no indication
// - Mode 101: version-2 event messages only
// - Enable bit 4 gates stamping, resets 0
// - Stamp readable as low and high words
// - Source identity split low and high
// - Sequence number in high attribute bits
// - EtherType match value, resets to PTP
// - Version 1 and 2 message match fields
// - UDP port match value, resets 0x319
module rpc_rx_stamp_capture
   import rpc_pkg::*;
(
   input logic sys_clk,
   input logic rst_b,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [RPC_ADDR_W-1:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input rpc_pkt_s rxPkt,
   input logic [63:0] sysTime,
   output logic stampToDesc,
   output logic irq
);

   // ****************************************************
   // Helpers
   // ****************************************************

   // Byte-lane merge shared by the control, match, port and mask registers
   function automatic logic [31:0] laneMerge(
      input logic [31:0] oldVal,
      input logic [31:0] newVal,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = newVal[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ****************************************************
   // Declarations
   // ****************************************************
   logic validReg;
   logic enReg;
   logic [2:0] modeReg;
   logic [31:0] matchReg;
   logic [15:0] udpReg;
   logic [RPC_IRQ_W-1:0] irqStatReg;
   logic [RPC_IRQ_W-1:0] irqMaskReg;
   logic [31:0] stampLowReg;
   logic [31:0] stampHighReg;
   logic [31:0] srcLowReg;
   logic [31:0] srcHighReg;
   logic [31:0] prdataReg;
   logic stampToDescReg;
   logic [31:0] ctrlWord;
   logic [31:0] rdValue;
   logic addrOk;
   logic setupPhase;
   logic accessPhase;
   logic wrAccess;
   logic readHigh;
   logic qualify;
   logic locked;
   logic hitNow;
   logic captureNow;
   logic lostNow;
   logic [RPC_IRQ_W-1:0] irqEvents;
   logic [RPC_IRQ_W-1:0] irqClear;
   logic [RPC_IRQ_W-1:0] irqStatNext;
   logic [31:0] ctrlMerged;
   rpc_match_s matchCfg;

   // ****************************************************
   // Bus phase decode
   // ****************************************************

   // Zero wait states: every access completes in one cycle
   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign wrAccess = accessPhase && pwrite;
   assign readHigh = accessPhase && !pwrite
      && (paddr == RPC_OFF_STAMP_HIGH);
   assign pready = 1'b1;
   assign pslverr = accessPhase && !addrOk;
   assign prdata = prdataReg;

   // ****************************************************
   // Classification and capture decision
   // ****************************************************
   assign matchCfg.mode = modeReg;
   assign matchCfg.etherType = matchReg[15:0];
   assign matchCfg.udpPort = udpReg;
   assign matchCfg.v1Control = matchReg[RPC_MATCH_V1_LSB +: 8];
   assign matchCfg.v2MessageId = matchReg[RPC_MATCH_V2_LSB +: 8];

   rpc_classifier u_classifier (
      .pkt(rxPkt),
      .cfg(matchCfg),
      .qualify(qualify)
   );

   // Stamp-all mode never locks, so later packets overwrite
   assign locked = validReg && (modeReg != RPC_MODE_ALL);
   assign hitNow = enReg && rxPkt.stampPoint && qualify;
   assign captureNow = hitNow && !locked;
   // A locked stamp drops the newer packet's time
   assign lostNow = hitNow && locked;

   // ****************************************************
   // Control register
   // ****************************************************
   always_comb begin
      ctrlWord = 32'h0;
      ctrlWord[RPC_CTRL_VALID_BIT] = validReg;
      ctrlWord[RPC_CTRL_TYPE_MSB:RPC_CTRL_TYPE_LSB] = modeReg;
      ctrlWord[RPC_CTRL_EN_BIT] = enReg;
   end

   assign ctrlMerged = laneMerge(ctrlWord, pwdata, pstrb);

   // Mode and enable; valid bit ignores writes
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         modeReg <= RPC_CTRL_TYPE_RST;
         enReg <= RPC_CTRL_EN_RST;
      end else if (wrAccess && paddr == RPC_OFF_CTRL) begin
         modeReg <= ctrlMerged[RPC_CTRL_TYPE_MSB:RPC_CTRL_TYPE_LSB];
         enReg <= ctrlMerged[RPC_CTRL_EN_BIT];
      end
   end

   // Valid flag; a capture in the read cycle wins
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         validReg <= 1'b0;
      end else if (captureNow) begin
         validReg <= 1'b1;
      end else if (readHigh) begin
         validReg <= 1'b0;
      end
   end

   // ****************************************************
   // Match configuration registers
   // ****************************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         matchReg <= RPC_MATCH_RST;
      end else if (wrAccess && paddr == RPC_OFF_MATCH) begin
         matchReg <= laneMerge(matchReg, pwdata, pstrb);
      end
   end

   // Upper half reserved, so only low lanes land
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         udpReg <= RPC_UDP_RST;
      end else if (wrAccess && paddr == RPC_OFF_UDP) begin
         udpReg <= 16'(laneMerge({16'h0, udpReg}, pwdata, pstrb));
      end
   end

   // ****************************************************
   // Capture registers
   // ****************************************************

   // Time and attributes are taken in the same edge
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stampLowReg <= 32'h0;
         stampHighReg <= 32'h0;
         srcLowReg <= 32'h0;
         srcHighReg <= 32'h0;
      end else if (captureNow) begin
         stampLowReg <= sysTime[31:0];
         stampHighReg <= sysTime[63:32];
         srcLowReg <= rxPkt.sourceId[31:0];
         srcHighReg <= {rxPkt.sequenceNum,
            rxPkt.sourceId[47:32]};
      end
   end

   // Descriptor indication, withheld in stamp-all mode
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stampToDescReg <= 1'b0;
      end else begin
         stampToDescReg <= captureNow
            && (modeReg != RPC_MODE_ALL);
      end
   end

   assign stampToDesc = stampToDescReg;

   // ****************************************************
   // Interrupt status and mask
   // ****************************************************
   always_comb begin
      irqEvents = '0;
      irqEvents[RPC_IRQ_CAPT_BIT] = captureNow;
      irqEvents[RPC_IRQ_LOST_BIT] = lostNow;
      irqClear = '0;
      if (wrAccess && paddr == RPC_OFF_IRQ_STAT && pstrb[0]) begin
         irqClear = pwdata[RPC_IRQ_W-1:0];
      end
      // New events win over a same-cycle clear
      irqStatNext = (irqStatReg & ~irqClear) | irqEvents;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStatReg <= '0;
      end else begin
         irqStatReg <= irqStatNext;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqMaskReg <= RPC_IRQ_MASK_RST;
      end else if (wrAccess && paddr == RPC_OFF_IRQ_MASK) begin
         irqMaskReg <= RPC_IRQ_W'(laneMerge({30'h0, irqMaskReg},
            pwdata, pstrb));
      end
   end

   // Level output, follows status one cycle after events
   assign irq = |(irqStatReg & irqMaskReg);

   // ****************************************************
   // Read path
   // ****************************************************
   always_comb begin
      rdValue = 32'h0;
      addrOk = 1'b1;
      case (paddr)
         RPC_OFF_CTRL: rdValue = ctrlWord;
         RPC_OFF_STAMP_LOW: rdValue = stampLowReg;
         RPC_OFF_STAMP_HIGH: rdValue = stampHighReg;
         RPC_OFF_SRC_LOW: rdValue = srcLowReg;
         RPC_OFF_SRC_HIGH: rdValue = srcHighReg;
         RPC_OFF_MATCH: rdValue = matchReg;
         RPC_OFF_UDP: rdValue = {16'h0, udpReg};
         RPC_OFF_IRQ_STAT: rdValue = {30'h0, irqStatReg};
         RPC_OFF_IRQ_MASK: rdValue = {30'h0, irqMaskReg};
         default: addrOk = 1'b0;
      endcase
   end

   // Sampled in setup so data is a flop in the access cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdataReg <= 32'h0;
      end else if (setupPhase && !pwrite) begin
         prdataReg <= rdValue;
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   property p_validSet;
      captureNow |=> validReg && stampToDesc == ($past(modeReg)
         != RPC_MODE_ALL);
   endproperty
   a_validSet: assert property (p_validSet)
      else $error("valid or indication wrong after capture");

   property p_validClear;
      readHigh && !captureNow |=> !validReg;
   endproperty
   a_validClear: assert property (p_validClear)
      else $error("valid survived high word read");

   property p_l2Only;
      modeReg == RPC_MODE_L2_V2 && hitNow |->
         rxPkt.isL2 && rxPkt.ptpVersion == RPC_PTP_V2;
   endproperty
   a_l2Only: assert property (p_l2Only)
      else $error("non layer-2 v2 packet stamped");

   property p_l4Only;
      modeReg == RPC_MODE_L4_V1 && hitNow |->
         rxPkt.isUdp && rxPkt.ptpVersion == RPC_PTP_V1;
   endproperty
   a_l4Only: assert property (p_l4Only)
      else $error("non UDP v1 packet stamped");

   property p_v2Any;
      modeReg == RPC_MODE_V2_ANY && hitNow |->
         rxPkt.ptpVersion == RPC_PTP_V2;
   endproperty
   a_v2Any: assert property (p_v2Any)
      else $error("non v2 packet stamped");

   property p_stampAll;
      enReg && modeReg == RPC_MODE_ALL && rxPkt.stampPoint
         |=> stampLowReg == $past(sysTime[31:0]) && !stampToDesc;
   endproperty
   a_stampAll: assert property (p_stampAll)
      else $error("stamp-all mode missed a packet");

   property p_eventOnly;
      modeReg == RPC_MODE_EVENT_V2 && hitNow |->
         !rxPkt.messageId[RPC_MSG_EVENT_BIT];
   endproperty
   a_eventOnly: assert property (p_eventOnly)
      else $error("general message stamped in event mode");

   property p_disabled;
      !enReg |-> !captureNow ##1 $stable(stampHighReg);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("capture while disabled");

   property p_attrs;
      captureNow |=> srcHighReg == {$past(rxPkt.sequenceNum),
         $past(rxPkt.sourceId[47:32])}
         && srcLowReg == $past(rxPkt.sourceId[31:0]);
   endproperty
   a_attrs: assert property (p_attrs)
      else $error("attributes not captured");

   property p_hold;
      locked && !readHigh |=> $stable(stampHighReg)
         && $stable(stampLowReg) && $stable(srcHighReg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("locked stamp changed");

endmodule // rpc_rx_stamp_capture

//--- tb_rx_ptp_timestamp_capture.sv
`timescale 1ns/1ps
module tb_rx_ptp_timestamp_capture
   import rpc_pkg::*;
();
   // ****************************************
   // Clock, reset, block and packet source
   // ****************************************
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic stampToDesc, irq;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [63:0] sysTime;
   rpc_pkt_s rxPkt;
   int failCount, testsRun, k;

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   rpc_rx_stamp_capture dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxPkt(rxPkt), .sysTime(sysTime),
      .stampToDesc(stampToDesc), .irq(irq));

   rpc_rx_path_model model (.sys_clk(sys_clk), .rst_b(rst_b),
      .rxPkt(rxPkt), .sysTime(sysTime));

   // ****************************************
   // Reporting and compares
   // ****************************************
   task automatic endOfTest();
      $display("Compares %0d, mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, exp, input string m);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk1(input logic got, exp, input string m);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("Error at %0t: %s got %b exp %b", $time, m, got, exp);
      end
   endtask

   // ****************************************
   // APB master; an idle edge after each transfer
   // ****************************************
   task automatic apb(input logic w, input logic [15:0] a,
         input logic [31:0] wd, output logic [31:0] rd, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failCount++;
         $display("Error at %0t: no ready", $time);
         endOfTest();
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      logic [31:0] d;
      logic e;
      apb(1'b1, a, v, d, e);
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 32'h0, d, e);
   endtask

   // Distinct identity and sequence per packet
   function automatic rpc_pkt_s mk(input logic l2, input logic [3:0] ver,
         input logic [3:0] msg, input logic [7:0] ctl);
      rpc_pkt_s p;
      k++;
      p.stampPoint = 1'b0;
      p.isL2 = l2;
      p.isUdp = !l2;
      p.etherType = l2 ? 16'h88f7 : 16'h0800;
      p.udpPort = l2 ? 16'h0000 : RPC_UDP_RST;
      p.ptpVersion = ver;
      p.messageId = msg;
      p.v1Control = ctl;
      p.sourceId = {16'h5a00 + 16'(k), 32'hc0de0000 + 32'(k)};
      p.sequenceNum = 16'h0100 + 16'(k);
      return p;
   endfunction

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_map();
      logic [15:0] adr [8] = '{RPC_OFF_CTRL, RPC_OFF_STAMP_LOW,
         RPC_OFF_STAMP_HIGH, RPC_OFF_SRC_LOW, RPC_OFF_SRC_HIGH,
         RPC_OFF_MATCH, RPC_OFF_IRQ_STAT, RPC_OFF_IRQ_MASK};
      logic [31:0] d;
      logic e;
      for (int i = 0; i < 8; i++) begin
         rd(adr[i], d);
         chk32(d, (i == 5) ? RPC_MATCH_RST : 32'h0, "reset value");
      end
      rd(RPC_OFF_UDP, d);
      chk32(d, {16'h0, RPC_UDP_RST}, "port reset");
      // Lane 0 only: upper byte of the port must survive
      pstrb <= 4'h1;
      wr(RPC_OFF_UDP, 32'hffffabcd);
      pstrb <= 4'hf;
      rd(RPC_OFF_UDP, d);
      chk32(d, 32'h000003cd, "lane write");
      wr(RPC_OFF_UDP, {16'h0, RPC_UDP_RST});
      apb(1'b0, 16'hb63c, 32'h0, d, e);
      chk1(e, 1'b1, "unmapped error");
      chk32(d, 32'h0, "unmapped data");
      wr(RPC_OFF_STAMP_LOW, 32'hffffffff);
      rd(RPC_OFF_STAMP_LOW, d);
      chk32(d, 32'h0, "read-only word");
      // Valid bit and upper bits must ignore the write
      wr(RPC_OFF_CTRL, 32'hfffffff5);
      rd(RPC_OFF_CTRL, d);
      chk32(d, 32'h14, "control fields");
   endtask

   // One packet under one mode; full readback when captured
   task automatic run_case(input logic en, input logic [2:0] md,
         input logic l2, input logic [3:0] ver, input logic [3:0] msg,
         input logic [7:0] ctl, input logic [7:0] mid, input logic exp);
      rpc_pkt_s p;
      logic [31:0] d;
      logic [63:0] t;
      p = mk(l2, ver, msg, ctl);
      wr(RPC_OFF_MATCH, {mid, 8'h0, 16'h88f7});
      // Callers only pass defined packet-type codes
      wr(RPC_OFF_CTRL, {27'h0, en, md, 1'b0});
      model.send(p);
      t = model.stampAt;
      #1 chk1(stampToDesc, exp && md != RPC_MODE_ALL, "indication");
      // Back onto the edge before the next bus request
      @(posedge sys_clk);
      rd(RPC_OFF_CTRL, d);
      chk1(d[0], exp, "valid set");
      if (exp) begin
         rd(RPC_OFF_STAMP_LOW, d);
         chk32(d, t[31:0], "stamp low");
         rd(RPC_OFF_STAMP_HIGH, d);
         chk32(d, t[63:32], "stamp high");
         rd(RPC_OFF_SRC_LOW, d);
         chk32(d, p.sourceId[31:0], "source low");
         rd(RPC_OFF_SRC_HIGH, d);
         chk32(d, {p.sequenceNum, p.sourceId[47:32]}, "sequence");
         rd(RPC_OFF_CTRL, d);
         chk1(d[0], 1'b0, "valid cleared");
      end
   endtask

   // Lock against a second packet, lost flag and interrupt masking
   task automatic lock_irq();
      rpc_pkt_s p;
      logic [31:0] d;
      logic [63:0] t;
      wr(RPC_OFF_IRQ_STAT, 32'h3);
      wr(RPC_OFF_IRQ_MASK, 32'h1);
      wr(RPC_OFF_MATCH, RPC_MATCH_RST);
      wr(RPC_OFF_CTRL, 32'h10);
      p = mk(1'b1, RPC_PTP_V2, 4'h0, 8'h0);
      model.send(p);
      t = model.stampAt;
      #1 chk1(irq, 1'b1, "irq on capture");
      @(posedge sys_clk);
      model.send(mk(1'b1, RPC_PTP_V2, 4'h0, 8'h0));
      rd(RPC_OFF_IRQ_STAT, d);
      chk32(d, 32'h3, "lost flagged");
      rd(RPC_OFF_SRC_LOW, d);
      chk32(d, p.sourceId[31:0], "held source");
      rd(RPC_OFF_STAMP_LOW, d);
      chk32(d, t[31:0], "held stamp");
      wr(RPC_OFF_IRQ_STAT, 32'h1);
      #1 chk1(irq, 1'b0, "lost masked");
      @(posedge sys_clk);
      wr(RPC_OFF_IRQ_MASK, 32'h2);
      #1 chk1(irq, 1'b1, "lost unmasked");
      @(posedge sys_clk);
      wr(RPC_OFF_IRQ_STAT, 32'h2);
      #1 chk1(irq, 1'b0, "irq cleared");
      @(posedge sys_clk);
      rd(RPC_OFF_STAMP_HIGH, d);
      // Stamp-all mode: a later packet overwrites
      wr(RPC_OFF_CTRL, 32'h18);
      model.send(mk(1'b1, RPC_PTP_V2, 4'h0, 8'h0));
      // Let the first packet's idle fields land before the next one
      @(posedge sys_clk);
      p = mk(1'b0, RPC_PTP_V1, 4'h0, 8'h9);
      model.send(p);
      rd(RPC_OFF_SRC_LOW, d);
      chk32(d, p.sourceId[31:0], "no lock");
      rd(RPC_OFF_STAMP_HIGH, d);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      failCount = 0;
      testsRun = 0;
      k = 0;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      reset_map();
      run_case(1'b0, 3'h0, 1'b1, 4'h2, 4'h0, 8'h0, 8'h0, 1'b0);
      run_case(1'b1, 3'h0, 1'b1, 4'h2, 4'h0, 8'h0, 8'h0, 1'b1);
      run_case(1'b1, 3'h0, 1'b0, 4'h2, 4'h0, 8'h0, 8'h0, 1'b0);
      run_case(1'b1, 3'h0, 1'b1, 4'h2, 4'h3, 8'h0, 8'h0, 1'b1);
      run_case(1'b1, 3'h0, 1'b1, 4'h2, 4'h1, 8'h0, 8'h0, 1'b0);
      run_case(1'b1, 3'h0, 1'b1, 4'h2, 4'h1, 8'h0, 8'h1, 1'b1);
      run_case(1'b1, 3'h1, 1'b0, 4'h1, 4'h0, 8'h0, 8'h0, 1'b1);
      run_case(1'b1, 3'h1, 1'b1, 4'h1, 4'h0, 8'h0, 8'h0, 1'b0);
      run_case(1'b1, 3'h1, 1'b0, 4'h1, 4'h0, 8'h5, 8'h0, 1'b0);
      run_case(1'b1, 3'h2, 1'b0, 4'h2, 4'h2, 8'h0, 8'h0, 1'b1);
      run_case(1'b1, 3'h2, 1'b1, 4'h1, 4'h0, 8'h0, 8'h0, 1'b0);
      run_case(1'b1, 3'h4, 1'b0, 4'h1, 4'h0, 8'h7, 8'h0, 1'b1);
      run_case(1'b1, 3'h5, 1'b1, 4'h2, 4'h8, 8'h0, 8'h0, 1'b0);
      run_case(1'b1, 3'h5, 1'b0, 4'h2, 4'h1, 8'h0, 8'h0, 1'b1);
      lock_irq();
      endOfTest();
   end
endmodule // tb_rx_ptp_timestamp_capture
